// *** verilog/ipp_phase_pulser.sv ***
`timescale 1ns/1ns
`include "ipp_defs.svh"
// Functional notes
// [RULE1] The master channel waveform is driven on its own output as the phase reference.
// [RULE2] A square wave at the switching frequency with exactly half duty is driven out.
// [RULE3] A rise seen on the rise sync input starts set timing for both slave channels.
// [RULE4] A fall seen on the fall sync input starts clear timing for both slave channels.
// [RULE5] Slave one set strobe lags the master by 120 degrees in three-channel and 180 in two-channel mode.
// [RULE6] Slave one clear strobe uses the same lag as its set strobe for the active mode.
// [RULE7] Slave two set strobe lags the master by 240 degrees.
// [RULE8] Slave two clear strobe lags the master clear by 240 degrees.
// [RULE9] Outside flip-flops take set strobes on set and clear strobes on reset to drive the slaves.
// [RULE10] The fault flag output is high in normal running and low while a fault is present.
// [RULE11] The start-up output is high during start-up or fault and low once start-up is done.
// [RULE12] Each rise of the mains square wave marks a mains zero crossing.
// [RULE13] The looped-back switching clock on the enable input blocks unwanted master commutations.
// [RULE14] The load level selects one, two or three channel operation.
// [RULE15] Strobes are one cycle wide and all timing state clears under reset; d1_reg instead reloads the 180-degree two-channel lag.

module ipp_phase_pulser #(
    parameter int PERIOD    = `IPP_PERIOD_CYCLES,
    parameter int LOAD_W    = `IPP_LOAD_W
) (
    // Clock and reset
    input  wire logic              CLK,
    input  wire logic              RESETN,
    // Master generation
    input  wire logic              COMP_LEVEL,
    input  wire logic              ENABLE_IN,
    output logic                   MASTER_PWM,
    output logic                   SWITCH_CLK,
    // Sync inputs
    input  wire logic              MASTER_RISE_SAMPLE,
    input  wire logic              MASTER_FALL_SAMPLE,
    // Slave strobes
    output logic                   SLAVE1_SET_STROBE,
    output logic                   SLAVE1_CLR_STROBE,
    output logic                   SLAVE2_SET_STROBE,
    output logic                   SLAVE2_CLR_STROBE,
    // Load level
    input  wire logic [LOAD_W-1:0] LOAD_LEVEL,
    // Status
    input  wire logic              FAULT_IN,
    input  wire logic              REG_OK,
    output logic                   FAULT_FLAG_N,
    output logic                   STARTUP_DONE_N,
    // Mains
    input  wire logic              MAINS_ZERO_CROSS,
    output logic                   ZERO_CROSS_EVT
);

    localparam int CNT_W  = $clog2(PERIOD) + 1;
    localparam int HALF   = PERIOD * `IPP_DUTY_PCT / `IPP_PCT_FULL;
    localparam int D1_3CH = PERIOD * `IPP_DEG_SLAVE1_3CH / `IPP_DEG_FULL;
    localparam int D1_2CH = PERIOD * `IPP_DEG_SLAVE1_2CH / `IPP_DEG_FULL;
    localparam int D2_3CH = PERIOD * `IPP_DEG_SLAVE2_3CH / `IPP_DEG_FULL;
    localparam int TH_TWO   = `IPP_LOAD_FULL * `IPP_LOAD_TWO_PCT / `IPP_PCT_FULL;
    localparam int TH_THREE = `IPP_LOAD_FULL * `IPP_LOAD_THREE_PCT / `IPP_PCT_FULL;

    logic [CNT_W-1:0]   per_cnt_reg;
    logic               clk_out_reg;
    logic               master_reg;
    logic               fired_reg;
    logic               rise_prev_reg;
    logic               fall_prev_reg;
    logic               zc_prev_reg;
    logic               zc_evt_reg;
    logic               fault_n_reg;
    logic               done_n_reg;
    ipp_pkg::ipp_mode_e mode_reg;
    ipp_pkg::ipp_mode_e mode_next;
    logic [CNT_W-1:0]   d1_reg;
    logic [CNT_W-1:0]   d1_next;
    logic               rise_evt;
    logic               fall_evt;
    logic               run;
    logic               s1_en;
    logic               s2_en;

    // ****************************************
    // Switching clock
    // ****************************************
    always_ff @(posedge CLK or negedge RESETN) begin
        if (!RESETN) begin
            per_cnt_reg <= '0;
        end else if (per_cnt_reg == CNT_W'(PERIOD - 1)) begin
            per_cnt_reg <= '0;
        end else begin
            per_cnt_reg <= per_cnt_reg + {{(CNT_W-1){1'b0}}, 1'b1};
        end
    end

    // [RULE2] Half-duty square wave
    always_ff @(posedge CLK or negedge RESETN) begin
        if (!RESETN) begin
            clk_out_reg <= 1'b0;
        end else begin
            clk_out_reg <= (per_cnt_reg < CNT_W'(HALF));
        end
    end

    // ****************************************
    // Master channel
    // ****************************************
    // [RULE13] One commutation per enable window
    always_ff @(posedge CLK or negedge RESETN) begin
        if (!RESETN) begin
            fired_reg <= 1'b0;
        end else if (!ENABLE_IN) begin
            fired_reg <= 1'b0;
        end else if (master_reg) begin
            fired_reg <= 1'b1;
        end
    end

    // [RULE1] Master waveform output
    always_ff @(posedge CLK or negedge RESETN) begin
        if (!RESETN) begin
            master_reg <= 1'b0;
        end else if (!fault_n_reg || !ENABLE_IN || !COMP_LEVEL) begin
            master_reg <= 1'b0;
        end else if (!fired_reg) begin
            master_reg <= 1'b1;
        end
    end

    // ****************************************
    // Sync edge detection
    // ****************************************
    always_ff @(posedge CLK or negedge RESETN) begin
        if (!RESETN) begin
            rise_prev_reg <= 1'b0;
            fall_prev_reg <= 1'b0;
        end else begin
            rise_prev_reg <= MASTER_RISE_SAMPLE;
            fall_prev_reg <= MASTER_FALL_SAMPLE;
        end
    end

    // [RULE3] Rise starts set timing
    assign rise_evt = MASTER_RISE_SAMPLE && !rise_prev_reg;
    // [RULE4] Fall starts clear timing
    assign fall_evt = !MASTER_FALL_SAMPLE && fall_prev_reg;

    // ****************************************
    // Channel count
    // ****************************************
    // [RULE14] Mode from load level
    always_comb begin
        if (LOAD_LEVEL >= LOAD_W'(TH_THREE)) begin
            mode_next = ipp_pkg::IPP_MODE_THREE;
        end else if (LOAD_LEVEL >= LOAD_W'(TH_TWO)) begin
            mode_next = ipp_pkg::IPP_MODE_TWO;
        end else begin
            mode_next = ipp_pkg::IPP_MODE_ONE;
        end
    end

    // [RULE5] Slave one lag per mode
    always_comb begin
        case (mode_next)
            ipp_pkg::IPP_MODE_THREE: d1_next = CNT_W'(D1_3CH);
            ipp_pkg::IPP_MODE_TWO:   d1_next = CNT_W'(D1_2CH);
            default:                 d1_next = CNT_W'(D1_2CH);
        endcase
    end

    // Mode and lag change only at master rise
    always_ff @(posedge CLK or negedge RESETN) begin
        if (!RESETN) begin
            mode_reg <= ipp_pkg::IPP_MODE_ONE;
            d1_reg   <= CNT_W'(D1_2CH);
        end else if (rise_evt) begin
            mode_reg <= mode_next;
            d1_reg   <= d1_next;
        end
    end

    assign run   = fault_n_reg;
    assign s1_en = run && (mode_reg != ipp_pkg::IPP_MODE_ONE);
    assign s2_en = run && (mode_reg == ipp_pkg::IPP_MODE_THREE);

    // ****************************************
    // Slave strobes
    // ****************************************
    // [RULE5] Slave one set timing
    ipp_delay_unit #(.CNT_W(CNT_W)) u_s1_set (
        .clk    (CLK),
        .resetn (RESETN),
        .start  (rise_evt),
        .delay  (d1_next),
        .en     (s1_en),
        .strobe (SLAVE1_SET_STROBE)
    );

    // [RULE6] Slave one clear, same lag
    ipp_delay_unit #(.CNT_W(CNT_W)) u_s1_clr (
        .clk    (CLK),
        .resetn (RESETN),
        .start  (fall_evt),
        .delay  (d1_reg),
        .en     (s1_en),
        .strobe (SLAVE1_CLR_STROBE)
    );

    // [RULE7] Slave two set timing
    ipp_delay_unit #(.CNT_W(CNT_W)) u_s2_set (
        .clk    (CLK),
        .resetn (RESETN),
        .start  (rise_evt),
        .delay  (CNT_W'(D2_3CH)),
        .en     (s2_en),
        .strobe (SLAVE2_SET_STROBE)
    );

    // [RULE8] Slave two clear timing
    ipp_delay_unit #(.CNT_W(CNT_W)) u_s2_clr (
        .clk    (CLK),
        .resetn (RESETN),
        .start  (fall_evt),
        .delay  (CNT_W'(D2_3CH)),
        .en     (s2_en),
        .strobe (SLAVE2_CLR_STROBE)
    );

    // ****************************************
    // Status and mains
    // ****************************************
    // [RULE10] Fault follows condition
    always_ff @(posedge CLK or negedge RESETN) begin
        if (!RESETN) begin
            fault_n_reg <= 1'b1;
        end else begin
            fault_n_reg <= !FAULT_IN;
        end
    end

    // [RULE11] Start-up done latch
    always_ff @(posedge CLK or negedge RESETN) begin
        if (!RESETN) begin
            done_n_reg <= 1'b1;
        end else if (FAULT_IN) begin
            done_n_reg <= 1'b1;
        end else if (REG_OK) begin
            done_n_reg <= 1'b0;
        end
    end

    // [RULE12] Mains rise detect
    always_ff @(posedge CLK or negedge RESETN) begin
        if (!RESETN) begin
            zc_prev_reg <= 1'b1;
            zc_evt_reg  <= 1'b0;
        end else begin
            zc_prev_reg <= MAINS_ZERO_CROSS;
            zc_evt_reg  <= MAINS_ZERO_CROSS && !zc_prev_reg;
        end
    end

    assign MASTER_PWM     = master_reg;
    assign SWITCH_CLK     = clk_out_reg;
    assign FAULT_FLAG_N   = fault_n_reg;
    assign STARTUP_DONE_N = done_n_reg;
    assign ZERO_CROSS_EVT = zc_evt_reg;

    // ****************************************
    // Assertions
    // ****************************************
    default clocking cb @(posedge CLK); endclocking
    default disable iff (!RESETN);

    master_source_a: assert property ($rose(MASTER_PWM) |-> $past(COMP_LEVEL && ENABLE_IN)) // [RULE1]
        else $error("master rose without compare and enable");
    clk_edges_a: assert property ($changed(SWITCH_CLK) |->
        ($past(per_cnt_reg) == '0 || $past(per_cnt_reg) == CNT_W'(HALF))) // [RULE2]
        else $error("switch clock edge off half period");
    enable_block_a: assert property (!ENABLE_IN |=> !MASTER_PWM) // [RULE13]
        else $error("master high with enable low");
    fault_flag_a: assert property (FAULT_IN |=> !FAULT_FLAG_N) // [RULE10]
        else $error("fault flag not low after fault");
    fault_quiet_a: assert property (!fault_n_reg |=> !SLAVE1_SET_STROBE && !SLAVE2_CLR_STROBE) // [RULE10]
        else $error("strobe during fault");
    startup_fault_a: assert property (FAULT_IN |=> STARTUP_DONE_N) // [RULE11]
        else $error("start-up output low during fault");
    strobe_width_a: assert property (SLAVE1_SET_STROBE |=> !SLAVE1_SET_STROBE) // [RULE15]
        else $error("set strobe wider than one cycle");
    slave2_mode_a: assert property (mode_reg != ipp_pkg::IPP_MODE_THREE |=> !SLAVE2_SET_STROBE) // [RULE7]
        else $error("slave two strobe outside three-channel mode");
    zero_cross_a: assert property ($rose(MAINS_ZERO_CROSS) |=> ZERO_CROSS_EVT ##1 !ZERO_CROSS_EVT) // [RULE12]
        else $error("zero crossing event missing or wide");

    master_rise_c:  cover property ($rose(MASTER_PWM));
    three_set_c:    cover property (SLAVE1_SET_STROBE && mode_reg == ipp_pkg::IPP_MODE_THREE);
    two_clr_c:      cover property (SLAVE1_CLR_STROBE && mode_reg == ipp_pkg::IPP_MODE_TWO);
    zero_cross_c:   cover property (ZERO_CROSS_EVT);

endmodule

// *** verilog/ipp_defs.svh ***
`ifndef IPP_DEFS_SVH
`define IPP_DEFS_SVH

// ****************************************
// Timing and phase constants
// ****************************************
`define IPP_PERIOD_CYCLES   2500
`define IPP_DEG_FULL        360
`define IPP_DEG_SLAVE1_3CH  120
`define IPP_DEG_SLAVE1_2CH  180
`define IPP_DEG_SLAVE2_3CH  240
`define IPP_DUTY_PCT        50
`define IPP_PCT_FULL        100

// ****************************************
// Load thresholds for channel count
// ****************************************
`define IPP_LOAD_W          8
`define IPP_LOAD_FULL       255
`define IPP_LOAD_TWO_PCT    30
`define IPP_LOAD_THREE_PCT  60

`endif

// *** verilog/ipp_pkg.sv ***
package ipp_pkg;

    // Gray coded channel-count modes
    typedef enum logic [1:0] {
        IPP_MODE_ONE   = 2'h0,
        IPP_MODE_TWO   = 2'h1,
        IPP_MODE_THREE = 2'h3
    } ipp_mode_e;

endpackage

// *** verilog/ipp_delay_unit.sv ***
`timescale 1ns/1ns

module ipp_delay_unit #(
    parameter int CNT_W = 12
) (
    // Clock and reset
    input  wire logic             clk,
    input  wire logic             resetn,
    // Control
    input  wire logic             start,
    input  wire logic [CNT_W-1:0] delay,
    input  wire logic             en,
    // Strobe out
    output logic                  strobe
);

    logic [CNT_W-1:0] cnt_reg;
    logic             strobe_reg;

    // ****************************************
    // Delay counter
    // ****************************************
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            cnt_reg <= '0;
        end else if (start && en) begin
            cnt_reg <= delay;
        end else if (!en) begin
            cnt_reg <= '0;
        end else if (cnt_reg != '0) begin
            cnt_reg <= cnt_reg - {{(CNT_W-1){1'b0}}, 1'b1};
        end
    end

    // [RULE15] One-cycle strobe
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            strobe_reg <= 1'b0;
        end else begin
            strobe_reg <= en && !start && (cnt_reg == {{(CNT_W-1){1'b0}}, 1'b1});
        end
    end

    assign strobe = strobe_reg;

endmodule

// *** testbench/ipp_board_model.sv ***
`timescale 1ns/1ns
// ********
// Board side
// ********
module ipp_board_model (
    // Clock and reset
    input  wire logic clk,
    input  wire logic resetn,
    // From block
    input  wire logic master_pwm,
    input  wire logic switch_clk,
    input  wire logic set1,
    input  wire logic clr1,
    input  wire logic set2,
    input  wire logic clr2,
    // To block and switches
    output logic      rise_smp,
    output logic      fall_smp,
    output logic      enable_out,
    output logic      drive1,
    output logic      drive2
);
    // Sync pins tied to master
    assign rise_smp = master_pwm;
    assign fall_smp = master_pwm;
    assign enable_out = switch_clk;
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) drive1 <= 1'b0;
        else if (set1) drive1 <= 1'b1;
        else if (clr1) drive1 <= 1'b0;
    end
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) drive2 <= 1'b0;
        else if (set2) drive2 <= 1'b1;
        else if (clr2) drive2 <= 1'b0;
    end
endmodule

// *** testbench/tb.sv ***
`timescale 1ns/1ns
// ********
// Bench
// ********
module tb;
    localparam int P = 60;
    localparam int D1T = P * 120 / 360;
    localparam int D1W = P * 180 / 360;
    localparam int D2 = P * 240 / 360;
    logic       clk, resetn, comp, fault, regok, mains;
    logic [7:0] load;
    wire        mpwm, sclk, s1s, s1c, s2s, s2c, ffn, sdn, zce;
    wire        rs, fs, en, dr1, dr2;
    wire  [3:0] stb = {s1s, s1c, s2s, s2c};
    int         error_cnt = 0, total_checks = 0, cyc = 0, n_mr = 0, n_z = 0, n_stb = 0, wide = 0;
    int         t_sr = 0, t_sf = 0, t_mr = 0, hi_len = 0, lo_len = 0, m_lag = 0;
    int         t_mf = -1, t_a = -1, t_b = -1, t_c = -1, t_d = -1, t_e = -1;
    logic       psc = 0, pm = 0, pd = 0;
    logic [3:0] pstb = 0;

    ipp_phase_pulser #(.PERIOD(P)) ipp_phase_pulser_inst (.CLK(clk), .RESETN(resetn), .COMP_LEVEL(comp),
        .ENABLE_IN(en), .MASTER_PWM(mpwm), .SWITCH_CLK(sclk), .MASTER_RISE_SAMPLE(rs), .MASTER_FALL_SAMPLE(fs),
        .SLAVE1_SET_STROBE(s1s), .SLAVE1_CLR_STROBE(s1c), .SLAVE2_SET_STROBE(s2s), .SLAVE2_CLR_STROBE(s2c),
        .LOAD_LEVEL(load), .FAULT_IN(fault), .REG_OK(regok), .FAULT_FLAG_N(ffn), .STARTUP_DONE_N(sdn),
        .MAINS_ZERO_CROSS(mains), .ZERO_CROSS_EVT(zce));
    ipp_board_model ipp_board_model_inst (.clk(clk), .resetn(resetn), .master_pwm(mpwm), .switch_clk(sclk),
        .set1(s1s), .clr1(s1c), .set2(s2s), .clr2(s2c), .rise_smp(rs), .fall_smp(fs), .enable_out(en),
        .drive1(dr1), .drive2(dr2));

    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end

    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            error_cnt++;
            $display("[ERR] %s expected %0h seen %0h", nm, exp, seen);
        end
    endtask

    task conclude();
        $display("Checks %0d errors %0d", total_checks, error_cnt);
        if (error_cnt == 0 && total_checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    task automatic step(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask

    task automatic wait_mr();
        int n;
        n = n_mr;
        for (int i = 0; i < 2 * P && n_mr == n; i++) step(1);
    endtask

    // Edge monitor
    always begin
        @(posedge clk);
        #2;
        cyc++;
        if (sclk === 1'b1 && psc === 1'b0) begin
            lo_len = cyc - t_sf;
            t_sr = cyc;
        end
        if (sclk === 1'b0 && psc === 1'b1) begin
            hi_len = cyc - t_sr;
            t_sf = cyc;
        end
        if (mpwm === 1'b1 && pm === 1'b0) begin
            n_mr++;
            t_mr = cyc;
            m_lag = cyc - t_sr;
        end
        if (mpwm === 1'b0 && pm === 1'b1 && t_mf < 0) t_mf = cyc;
        if (s1s === 1'b1 && t_a < 0) t_a = cyc;
        if (s1c === 1'b1 && t_b < 0 && t_mf >= 0) t_b = cyc;
        if (s2s === 1'b1 && t_c < 0) t_c = cyc;
        if (s2c === 1'b1 && t_d < 0 && t_mf >= 0) t_d = cyc;
        if (dr1 === 1'b1 && pd === 1'b0 && t_e < 0) t_e = cyc;
        if ((stb & pstb) !== 4'h0) wide++;
        if (stb !== 4'h0) n_stb++;
        if (zce === 1'b1) n_z++;
        psc = sclk;
        pm = mpwm;
        pd = dr1;
        pstb = stb;
        if (cyc > 20000) begin
            error_cnt++;
            conclude();
        end
    end

    task automatic t_reset(input int n);
        resetn = 1'b0;
        step(n);
        chk("rst_out", {mpwm, sclk, stb, zce}, 7'h00);
        chk("rst_fault", ffn, 1'b1);
        chk("rst_startup", sdn, 1'b1);
        resetn = 1'b1;
        step(1);
    endtask

    task automatic t_clk();
        step(2 * P);
        chk("clk_high", hi_len, P / 2);
        chk("clk_low", lo_len, P / 2);
    endtask

    task automatic t_phase(input logic [7:0] lv, input int d1, input logic on1, input logic on2);
        int r;
        load = lv;
        step(P);
        wait_mr();
        r = t_mr;
        {t_mf, t_a, t_b, t_c, t_d, t_e} = {6{-32'sd1}};
        step(2 * P);
        chk("m_lag", m_lag, 1);
        chk("s1_set", t_a < 0 ? -1 : t_a - r, on1 ? d1 + 1 : -1);
        chk("s1_clr", t_b < 0 ? -1 : t_b - t_mf, on1 ? d1 + 1 : -1);
        chk("s2_set", t_c < 0 ? -1 : t_c - r, on2 ? D2 + 1 : -1);
        chk("s2_clr", t_d < 0 ? -1 : t_d - t_mf, on2 ? D2 + 1 : -1);
        chk("drive1", t_e < 0 ? -1 : t_e - r, on1 ? d1 + 2 : -1);
    endtask

    task automatic t_block();
        int n;
        wait_mr();
        n = n_mr;
        step(5);
        comp = 1'b0;
        step(3);
        comp = 1'b1;
        step(5);
        chk("blocked", mpwm, 1'b0);
        step(P);
        chk("next_fire", n_mr - n, 1);
    endtask

    task automatic t_status();
        int s0, m0;
        regok = 1'b1;
        step(1);
        chk("done", sdn, 1'b0);
        regok = 1'b0;
        step(3);
        chk("done_held", sdn, 1'b0);
        fault = 1'b1;
        step(1);
        chk("fault_low", ffn, 1'b0);
        chk("fault_su", sdn, 1'b1);
        step(2);
        s0 = n_stb;
        m0 = n_mr;
        step(2 * P);
        chk("fault_stb", n_stb - s0, 0);
        chk("fault_pwm", n_mr - m0, 0);
        fault = 1'b0;
        step(1);
        chk("fault_high", ffn, 1'b1);
    endtask

    task automatic t_mains();
        int z0;
        mains = 1'b1;
        step(1);
        chk("zc_evt", zce, 1'b1);
        z0 = n_z;
        step(8);
        chk("zc_once", n_z - z0, 1);
        mains = 1'b0;
        step(2);
    endtask

    initial begin
        resetn = 1'b0;
        comp = 1'b1;
        fault = 1'b0;
        regok = 1'b0;
        mains = 1'b0;
        load = 8'hc8;
        t_reset(6);
        t_clk();
        t_phase(8'hc8, D1T, 1'b1, 1'b1);
        t_phase(8'h99, D1T, 1'b1, 1'b1);
        t_phase(8'h98, D1W, 1'b1, 1'b0);
        t_phase(8'h4c, D1W, 1'b1, 1'b0);
        t_phase(8'h4b, 0, 1'b0, 1'b0);
        t_block();
        t_status();
        t_mains();
        t_reset(2);
        chk("stb_width", wide, 0);
        conclude();
    end
endmodule
